//--- design/ocs_cmd_status.sv
// command status register bank with overrun count, list filled bits and soft reset
// assumes list engine pulses on the same clock and a classic wishbone master
//
// Our own choice: the Wishbone register port.
module ocs_cmd_status
  import ocs_pkg::*;
#(
  parameter int SRST_CYCLES = 32
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic [31:0]       wb_dat_o,
  output logic              wb_ack_o,
  input  wire ocs_list_ev_t list_ev,
  output logic              irq,
  output logic              bulk_active,
  output logic              control_active,
  output logic              suspended_state,
  output logic              host_bus_enable,
  output logic              ops_reset
);

  // ***********************************************
  // parameter check
  // ***********************************************
  if (SRST_CYCLES < 1 || SRST_CYCLES > OCS_SRST_MAX_CYC ||
      SRST_CYCLES >= (1 << OCS_SRST_CNT_W)) begin : g_bad_srst
    $error("SRST_CYCLES out of range");
  end

  localparam logic [OCS_SRST_CNT_W-1:0] SRST_LAST = OCS_SRST_CNT_W'(SRST_CYCLES - 1);

  // ***********************************************
  // helpers
  // ***********************************************
  function automatic logic [31:0] be_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{sel[i]}};
    end
    return m;
  endfunction

  function automatic logic addr_hit(input logic [7:0] adr, input logic [7:0] reg_adr);
    return adr[7:2] == reg_adr[7:2];
  endfunction

  ocs_state_t q;
  ocs_state_t d;

  logic        req;
  logic        wr;
  logic        rd;
  logic [31:0] wm;
  logic        wr_cmd;
  logic        wr_istat;
  logic        wr_imask;

  assign req      = wb_cyc_i && wb_stb_i && !q.ack;
  // write lands at the edge where the master samples ack
  assign wr       = wb_cyc_i && wb_stb_i && wb_we_i && q.ack;
  assign rd       = req && !wb_we_i;
  assign wm       = wb_dat_i & be_mask(wb_sel_i);
  assign wr_cmd   = wr && addr_hit(wb_adr_i, OCS_ADDR_CMD);
  assign wr_istat = wr && addr_hit(wb_adr_i, OCS_ADDR_ISTAT);
  assign wr_imask = wr && addr_hit(wb_adr_i, OCS_ADDR_IMASK);

  // ***********************************************
  // next state
  // ***********************************************
  always_comb begin
    logic blf_clr;
    logic clf_clr;
    logic srst_go;
    blf_clr = 1'b0;
    clf_clr = 1'b0;
    srst_go = 1'b0;
    d = q;
    d.ack = req;
    d.rdata = 32'h00000000;
    if (rd) begin
      // reserved bits read as zero
      if (addr_hit(wb_adr_i, OCS_ADDR_CMD)) begin
        d.rdata[OCS_SOC_LO +: 2] = q.soc;
        d.rdata[OCS_OCR_BIT] = q.ownership_change_request;
        d.rdata[OCS_BLF_BIT] = q.bulk_list_filled;
        d.rdata[OCS_CLF_BIT] = q.control_list_filled;
        d.rdata[OCS_HCR_BIT] = q.controller_soft_reset;
      end else if (addr_hit(wb_adr_i, OCS_ADDR_ISTAT)) begin
        d.rdata[OCS_SO_BIT] = q.so_flag;
        d.rdata[OCS_OC_BIT] = q.ownership_changed_flag;
      end else if (addr_hit(wb_adr_i, OCS_ADDR_IMASK)) begin
        d.rdata[OCS_SO_BIT] = q.so_mask;
        d.rdata[OCS_OC_BIT] = q.oc_mask;
      end
    end

    // overrun count: write-one-to-set then increment, wraps at three
    d.soc = (q.soc | (wr_cmd ? wm[OCS_SOC_LO +: 2] : 2'h0)) +
            {1'b0, list_ev.sched_overrun};

    // interrupt status: write one clears, event set wins
    if (wr_istat && wm[OCS_SO_BIT]) begin
      d.so_flag = 1'b0;
    end
    if (wr_istat && wm[OCS_OC_BIT]) begin
      d.ownership_changed_flag = 1'b0;
    end
    if (list_ev.sched_overrun) begin
      d.so_flag = 1'b1;
    end

    // ownership request
    if (list_ev.ownership_done) begin
      d.ownership_change_request = 1'b0;
    end
    if (wr_cmd && wm[OCS_OCR_BIT]) begin
      d.ownership_change_request = 1'b1;
      d.ownership_changed_flag = 1'b1;
    end

    // bulk list
    if (list_ev.bulk_start) begin
      if (q.bulk_list_filled) begin
        d.bulk_active = 1'b1;
        blf_clr = 1'b1;
      end else if (!q.bulk_active) begin
        d.bulk_active = 1'b0;
      end
    end
    if (list_ev.bulk_done && !q.bulk_list_filled && !list_ev.bulk_td_found &&
        !(wr_cmd && wm[OCS_BLF_BIT])) begin
      d.bulk_active = 1'b0;
    end
    d.bulk_list_filled = (q.bulk_list_filled && !blf_clr) ||
                         list_ev.bulk_td_found ||
                         (wr_cmd && wm[OCS_BLF_BIT]);

    // control list
    if (list_ev.control_start) begin
      if (q.control_list_filled) begin
        d.control_active = 1'b1;
        clf_clr = 1'b1;
      end else if (!q.control_active) begin
        d.control_active = 1'b0;
      end
    end
    if (list_ev.control_done && !q.control_list_filled && !list_ev.control_td_found &&
        !(wr_cmd && wm[OCS_CLF_BIT])) begin
      d.control_active = 1'b0;
    end
    d.control_list_filled = (q.control_list_filled && !clf_clr) ||
                            list_ev.control_td_found ||
                            (wr_cmd && wm[OCS_CLF_BIT]);

    // mask
    if (wr_imask) begin
      d.so_mask = wm[OCS_SO_BIT];
      d.oc_mask = wm[OCS_OC_BIT];
    end

    // soft reset sequence
    srst_go = wr_cmd && wm[OCS_HCR_BIT];
    case (q.fsm)
      OCS_RUN: begin
        if (srst_go) begin
          d.fsm = OCS_SRST;
          d.controller_soft_reset = 1'b1;
          d.srst_cnt = '0;
          // operational state back to reset; routing lives outside and is kept
          d.soc = OCS_SOC_RST;
          d.ownership_change_request = 1'b0;
          d.bulk_list_filled = 1'b0;
          d.control_list_filled = 1'b0;
          d.bulk_active = 1'b0;
          d.control_active = 1'b0;
          d.so_flag = 1'b0;
          d.ownership_changed_flag = 1'b0;
          d.suspended_state = 1'b1;
          d.bus_enable = 1'b0;
          d.ops_reset = 1'b1;
        end
      end
      OCS_SRST: begin
        d.bulk_active = 1'b0;
        d.control_active = 1'b0;
        if (q.srst_cnt == SRST_LAST) begin
          d.fsm = OCS_RUN;
          d.controller_soft_reset = 1'b0;
          d.bus_enable = 1'b1;
          d.ops_reset = 1'b0;
        end else begin
          d.srst_cnt = q.srst_cnt + OCS_SRST_CNT_W'(1);
        end
      end
      default: begin
        d.fsm = OCS_RUN;
      end
    endcase

    d.irq = (d.so_flag && d.so_mask) || (d.ownership_changed_flag && d.oc_mask);
  end

  // ***********************************************
  // state register
  // ***********************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{
        ack:                      1'b0,
        rdata:                    32'h00000000,
        soc:                      OCS_SOC_RST,
        ownership_change_request: OCS_CMD_RST[OCS_OCR_BIT],
        bulk_list_filled:         OCS_CMD_RST[OCS_BLF_BIT],
        control_list_filled:      OCS_CMD_RST[OCS_CLF_BIT],
        controller_soft_reset:    OCS_CMD_RST[OCS_HCR_BIT],
        bulk_active:              1'b0,
        control_active:           1'b0,
        so_flag:                  1'b0,
        ownership_changed_flag:   1'b0,
        so_mask:                  OCS_IMASK_RST[OCS_SO_BIT],
        oc_mask:                  OCS_IMASK_RST[OCS_OC_BIT],
        irq:                      1'b0,
        suspended_state:          1'b0,
        bus_enable:               1'b1,
        ops_reset:                1'b0,
        srst_cnt:                 '0,
        fsm:                      OCS_RUN
      };
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o        = q.rdata;
  assign wb_ack_o        = q.ack;
  assign irq             = q.irq;
  assign bulk_active     = q.bulk_active;
  assign control_active  = q.control_active;
  assign suspended_state = q.suspended_state;
  assign host_bus_enable = q.bus_enable;
  assign ops_reset       = q.ops_reset;

  // ***********************************************
  // assertions
  // ***********************************************
  logic srst_go_w;
  assign srst_go_w = wr_cmd && wb_dat_i[OCS_HCR_BIT] && wb_sel_i[0] && q.fsm == OCS_RUN;

  sequence s_srst_req;
    srst_go_w;
  endsequence

  sequence s_srst_hold;
    (q.controller_soft_reset && !q.bus_enable && q.suspended_state) [*1];
  endsequence

  property p_soc_inc;
    @(posedge clk) disable iff (!rst_n)
      (list_ev.sched_overrun && !wr_cmd) |=> (q.soc == $past(q.soc) + 2'h1);
  endproperty
  a_soc_inc: assert property (p_soc_inc) else $error("overrun count did not advance");

  property p_soc_when_set;
    @(posedge clk) disable iff (!rst_n)
      (list_ev.sched_overrun && q.so_flag && !wr) |=> (q.soc != $past(q.soc)) && q.so_flag;
  endproperty
  a_soc_when_set: assert property (p_soc_when_set) else $error("count held with flag set");

  property p_ovr_flag;
    @(posedge clk) disable iff (!rst_n)
      list_ev.sched_overrun && !srst_go_w |=> q.so_flag;
  endproperty
  a_ovr_flag: assert property (p_ovr_flag) else $error("overrun flag not set");

  property p_ocr_set;
    @(posedge clk) disable iff (!rst_n)
      (wr_cmd && wm[OCS_OCR_BIT] && !srst_go_w) |=>
        q.ownership_change_request && q.ownership_changed_flag;
  endproperty
  a_ocr_set: assert property (p_ocr_set) else $error("ownership change not flagged");

  property p_ocr_clr;
    @(posedge clk) disable iff (!rst_n)
      (list_ev.ownership_done && !(wr_cmd && wm[OCS_OCR_BIT])) |=>
        !q.ownership_change_request;
  endproperty
  a_ocr_clr: assert property (p_ocr_clr) else $error("ownership request not cleared");

  property p_blf_w1s;
    @(posedge clk) disable iff (!rst_n)
      (wr_cmd && wm[OCS_BLF_BIT] && !srst_go_w) |=> q.bulk_list_filled;
  endproperty
  a_blf_w1s: assert property (p_blf_w1s) else $error("bulk filled write lost");

  property p_bulk_skip;
    @(posedge clk) disable iff (!rst_n)
      (list_ev.bulk_start && !q.bulk_list_filled && !q.bulk_active) |=> !q.bulk_active;
  endproperty
  a_bulk_skip: assert property (p_bulk_skip) else $error("empty bulk list started");

  property p_bulk_start;
    @(posedge clk) disable iff (!rst_n)
      (list_ev.bulk_start && q.bulk_list_filled && !list_ev.bulk_td_found && !wr_cmd &&
       q.fsm == OCS_RUN) |=> q.bulk_active && !q.bulk_list_filled;
  endproperty
  a_bulk_start: assert property (p_bulk_start) else $error("bulk start wrong");

  property p_bulk_td;
    @(posedge clk) disable iff (!rst_n)
      list_ev.bulk_td_found && !srst_go_w |=> q.bulk_list_filled;
  endproperty
  a_bulk_td: assert property (p_bulk_td) else $error("bulk td did not set filled");

  property p_bulk_stop;
    @(posedge clk) disable iff (!rst_n)
      (list_ev.bulk_done && !q.bulk_list_filled && !list_ev.bulk_td_found &&
       !list_ev.bulk_start && !wr_cmd) |=> !q.bulk_active;
  endproperty
  a_bulk_stop: assert property (p_bulk_stop) else $error("bulk did not stop");

  property p_ctrl_start;
    @(posedge clk) disable iff (!rst_n)
      (list_ev.control_start && q.control_list_filled && !list_ev.control_td_found &&
       !wr_cmd && q.fsm == OCS_RUN) |=> q.control_active && !q.control_list_filled;
  endproperty
  a_ctrl_start: assert property (p_ctrl_start) else $error("control start wrong");

  property p_ctrl_stop;
    @(posedge clk) disable iff (!rst_n)
      (list_ev.control_done && !q.control_list_filled && !list_ev.control_td_found &&
       !list_ev.control_start && !wr_cmd) |=> !q.control_active;
  endproperty
  a_ctrl_stop: assert property (p_ctrl_stop) else $error("control did not stop");

  property p_srst_enter;
    @(posedge clk) disable iff (!rst_n)
      s_srst_req |=> s_srst_hold ##0 (q.soc == OCS_SOC_RST) && !q.bulk_list_filled;
  endproperty
  a_srst_enter: assert property (p_srst_enter) else $error("soft reset entry wrong");

  property p_srst_nobus;
    @(posedge clk) disable iff (!rst_n)
      q.controller_soft_reset |-> !q.bus_enable && q.suspended_state;
  endproperty
  a_srst_nobus: assert property (p_srst_nobus) else $error("bus enabled in soft reset");

  property p_srst_done;
    @(posedge clk) disable iff (!rst_n)
      s_srst_req |=> q.controller_soft_reset ##[1:1000] !q.controller_soft_reset;
  endproperty
  a_srst_done: assert property (p_srst_done) else $error("soft reset too long");

  property p_rsvd_zero;
    @(posedge clk) disable iff (!rst_n)
      $past(rd) && $past(addr_hit(wb_adr_i, OCS_ADDR_CMD)) |->
        (q.rdata & 32'hfffcfff0) == 32'h00000000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");

endmodule

//--- design/ocs_pkg.sv
// command and status register constants and shared types
// assumes a single 100 MHz controller clock and a classic wishbone slave port
package ocs_pkg;

  // ***********************************************
  // register map
  // ***********************************************
  localparam logic [7:0]  OCS_ADDR_CMD   = 8'h08;
  localparam logic [7:0]  OCS_ADDR_ISTAT = 8'h0c;
  localparam logic [7:0]  OCS_ADDR_IMASK = 8'h10;
  localparam int          OCS_HCR_BIT    = 0;
  localparam int          OCS_CLF_BIT    = 1;
  localparam int          OCS_BLF_BIT    = 2;
  localparam int          OCS_OCR_BIT    = 3;
  localparam int          OCS_SOC_LO     = 16;
  localparam int          OCS_SO_BIT     = 0;
  localparam int          OCS_OC_BIT     = 30;
  localparam logic [31:0] OCS_CMD_RST    = 32'h00000000;
  localparam logic [31:0] OCS_IMASK_RST  = 32'h00000000;
  localparam logic [1:0]  OCS_SOC_RST    = 2'h0;

  // ***********************************************
  // timing
  // ***********************************************
  localparam int OCS_CLK_PERIOD_NS = 10;
  localparam int OCS_SRST_TIME_NS  = 10000;
  localparam int OCS_SRST_MAX_CYC  = OCS_SRST_TIME_NS / OCS_CLK_PERIOD_NS;
  localparam int OCS_SRST_CNT_W    = 10;

  // ***********************************************
  // types
  // ***********************************************
  typedef enum logic [0:0] {
    OCS_RUN,
    OCS_SRST
  } ocs_fsm_t;

  // pulses from the list walking engine, same clock
  typedef struct packed {
    logic sched_overrun;
    logic bulk_start;
    logic bulk_td_found;
    logic bulk_done;
    logic control_start;
    logic control_td_found;
    logic control_done;
    logic ownership_done;
  } ocs_list_ev_t;

  typedef struct packed {
    logic                      ack;
    logic [31:0]               rdata;
    logic [1:0]                soc;
    logic                      ownership_change_request;
    logic                      bulk_list_filled;
    logic                      control_list_filled;
    logic                      controller_soft_reset;
    logic                      bulk_active;
    logic                      control_active;
    logic                      so_flag;
    logic                      ownership_changed_flag;
    logic                      so_mask;
    logic                      oc_mask;
    logic                      irq;
    logic                      suspended_state;
    logic                      bus_enable;
    logic                      ops_reset;
    logic [OCS_SRST_CNT_W-1:0] srst_cnt;
    ocs_fsm_t                  fsm;
  } ocs_state_t;

endpackage

//--- test/ocs_cmd_status_tb.sv
// self-checking bench for the command status register bank
// assumes the bank answers wishbone one cycle after taking a request
module ocs_cmd_status_tb
  import ocs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int SRST_N = 20;

  logic         clk;
  logic         rst_n;
  logic         wb_cyc_i;
  logic         wb_stb_i;
  logic         wb_we_i;
  logic [7:0]   wb_adr_i;
  logic [3:0]   wb_sel_i;
  logic [31:0]  wb_dat_i;
  logic [31:0]  wb_dat_o;
  logic         wb_ack_o;
  ocs_list_ev_t list_ev;
  logic         irq;
  logic         bulk_active;
  logic         control_active;
  logic         suspended_state;
  logic         host_bus_enable;
  logic         ops_reset;
  int           errors;
  int           checked;
  logic [31:0]  cmd_m;
  logic [31:0]  stat_m;
  logic [31:0]  mask_m;
  logic [31:0]  rd;
  int           n;
  int           fb;
  int           base;
  logic [31:0]  w;

  ocs_cmd_status #(.SRST_CYCLES(SRST_N)) dut (
    .clk             (clk),
    .rst_n           (rst_n),
    .wb_cyc_i        (wb_cyc_i),
    .wb_stb_i        (wb_stb_i),
    .wb_we_i         (wb_we_i),
    .wb_adr_i        (wb_adr_i),
    .wb_sel_i        (wb_sel_i),
    .wb_dat_i        (wb_dat_i),
    .wb_dat_o        (wb_dat_o),
    .wb_ack_o        (wb_ack_o),
    .list_ev         (list_ev),
    .irq             (irq),
    .bulk_active     (bulk_active),
    .control_active  (control_active),
    .suspended_state (suspended_state),
    .host_bus_enable (host_bus_enable),
    .ops_reset       (ops_reset)
  );

  // ***********************************************
  // clock, compare and closing
  // ***********************************************
  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    finish_test();
  end

  // ***********************************************
  // wishbone and event drivers
  // ***********************************************
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] adr, input logic [31:0] exp);
    wb_cycle(1'b0, adr, 32'h00000000);
    chk(name, rd, exp);
  endtask

  // model of write-one-to-set and write-one-to-clear
  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    wb_cycle(1'b1, adr, d);
    if (adr == OCS_ADDR_CMD) begin
      cmd_m = cmd_m | (d & 32'h0003000f);
      if (d[OCS_OCR_BIT]) stat_m[OCS_OC_BIT] = 1'b1;
    end
    if (adr == OCS_ADDR_ISTAT) stat_m = stat_m & ~(d & 32'h40000001);
    if (adr == OCS_ADDR_IMASK) mask_m = d & 32'h40000001;
  endtask

  task automatic pulse(input int k);
    @(posedge clk);
    list_ev <= ocs_list_ev_t'(8'h01 << k);
    @(posedge clk);
    list_ev <= '0;
    @(negedge clk);
  endtask

  // ***********************************************
  // main sequence
  // ***********************************************
  initial begin
    errors = 0;
    checked = 0;
    cmd_m = OCS_CMD_RST;
    stat_m = 32'h0;
    mask_m = OCS_IMASK_RST;
    rst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    list_ev = '0;
    void'($urandom(32'haf7da52f));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk("cmd reset", OCS_ADDR_CMD, OCS_CMD_RST);
    chk("bus enable reset", {31'h0, host_bus_enable}, 32'h1);
    // overrun count wraps, flag sticky, interrupt follows mask
    wr(OCS_ADDR_IMASK, 32'h40000001);
    n = 5 + int'($urandom % 4);
    for (int i = 0; i < n; i++) begin
      pulse(7);
      cmd_m[17:16] = cmd_m[17:16] + 2'h1;
      stat_m[OCS_SO_BIT] = 1'b1;
      chk("irq overrun", {31'h0, irq}, 32'h1);
      rd_chk("overrun count", OCS_ADDR_CMD, cmd_m);
    end
    rd_chk("status overrun", OCS_ADDR_ISTAT, stat_m);
    wr(OCS_ADDR_ISTAT, 32'h00000001);
    @(negedge clk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    wr(OCS_ADDR_IMASK, 32'h40000000);
    pulse(7);
    cmd_m[17:16] = cmd_m[17:16] + 2'h1;
    stat_m[OCS_SO_BIT] = 1'b1;
    chk("irq masked", {31'h0, irq}, 32'h0);
    rd_chk("mask readback", OCS_ADDR_IMASK, mask_m);
    // write one to set, reserved bits kept zero, unmapped place
    w = $urandom & 32'h00030006;
    wr(OCS_ADDR_CMD, w);
    rd_chk("reserved read zero", OCS_ADDR_CMD, cmd_m);
    wr(OCS_ADDR_CMD, 32'h00000006);
    wr(OCS_ADDR_CMD, 32'h00000000);
    rd_chk("zero keeps bits", OCS_ADDR_CMD, cmd_m);
    wr(8'hf0, 32'hffffffff);
    rd_chk("unmapped read", 8'hf0, 32'h0);
    rd_chk("unmapped write ignored", OCS_ADDR_CMD, cmd_m);
    // bulk then control list filled handling
    for (int i = 0; i < 2; i++) begin
      base = (i == 0) ? 6 : 3;
      fb = (i == 0) ? OCS_BLF_BIT : OCS_CLF_BIT;
      pulse(base);
      cmd_m[fb] = 1'b0;
      chk("active on start", {31'h0, i ? control_active : bulk_active}, 32'h1);
      rd_chk("filled cleared", OCS_ADDR_CMD, cmd_m);
      pulse(base - 1);
      cmd_m[fb] = 1'b1;
      rd_chk("td found sets", OCS_ADDR_CMD, cmd_m);
      pulse(base - 2);
      chk("done keeps active", {31'h0, i ? control_active : bulk_active}, 32'h1);
      pulse(base);
      cmd_m[fb] = 1'b0;
      pulse(base - 2);
      chk("done stops", {31'h0, i ? control_active : bulk_active}, 32'h0);
      pulse(base);
      chk("empty start skips", {31'h0, i ? control_active : bulk_active}, 32'h0);
      rd_chk("filled stays zero", OCS_ADDR_CMD, cmd_m);
    end
    // ownership change request and changeover
    wr(OCS_ADDR_CMD, 32'h00000008);
    rd_chk("ownership status", OCS_ADDR_ISTAT, stat_m);
    @(negedge clk);
    chk("irq ownership", {31'h0, irq}, 32'h1);
    pulse(0);
    cmd_m[OCS_OCR_BIT] = 1'b0;
    rd_chk("request cleared", OCS_ADDR_CMD, cmd_m);
    repeat (3) @(posedge clk);
    rd_chk("request stays clear", OCS_ADDR_CMD, cmd_m);
    // soft reset with state present
    wr(OCS_ADDR_CMD, 32'h00000006);
    pulse(7);
    wr(OCS_ADDR_CMD, 32'h00000001);
    @(negedge clk);
    chk("suspend forced", {31'h0, suspended_state}, 32'h1);
    chk("ops reset", {31'h0, ops_reset}, 32'h1);
    chk("bus held off", {31'h0, host_bus_enable}, 32'h0);
    n = 0;
    while (host_bus_enable !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    chk("reset within bound", {31'h0, n <= SRST_N}, 32'h1);
    chk("ops reset done", {31'h0, ops_reset}, 32'h0);
    chk("suspend kept", {31'h0, suspended_state}, 32'h1);
    rd_chk("cmd after reset", OCS_ADDR_CMD, 32'h0);
    rd_chk("status after reset", OCS_ADDR_ISTAT, 32'h0);
    rd_chk("mask kept", OCS_ADDR_IMASK, mask_m);
    finish_test();
  end

endmodule
